// [hw/sfm_pkg.sv]
// Package for the forward mask stages: sizes, register map and carriers
`default_nettype none
package sfm_pkg;
	localparam int PORTS = 11;
	localparam int QUEUES = 8;
	localparam int AGG_MASKS = 16;
	localparam int AGG_BASE = 64;
	localparam int SRC_BASE = 80;
	localparam int TABLE_TOP = 106;
	localparam int TABLE_ENTRIES = TABLE_TOP - AGG_BASE + 1;
	localparam int SRC_SLOT = SRC_BASE - AGG_BASE;
	localparam int POLICERS_W = 5;
	localparam int COUNT_W = 16;
	// Register byte addresses
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] FILTER_ADDR = 12'h004;
	localparam logic [11:0] ISOLATED_ADDR = 12'h008;
	localparam logic [11:0] COMMUNITY_ADDR = 12'h00C;
	localparam logic [11:0] RXEN_ADDR = 12'h010;
	localparam logic [11:0] STATUS_ADDR = 12'h014;
	localparam logic [11:0] TABLE_ADDR = 12'h100;
	localparam logic [11:0] TABLE_END = 12'h1A8;
	// Control field positions
	localparam int CTRL_SKIP_FORWARD_PORT_SET = 0;
	localparam int CTRL_FLOOD_SKIP = 1;
	localparam int CTRL_LEARN_CHECK = 2;
	localparam int CTRL_W = 3;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [PORTS-1:0] ALL_PORTS = 11'h7FF;
	localparam logic [PORTS-1:0] NO_PORTS = 11'h000;
	localparam logic [QUEUES-1:0] NO_QUEUES = 8'h00;
	// Mask modes of a rule action
	typedef enum logic [1:0] {
		SFM_MODE_NONE = 2'b00,
		SFM_MODE_PERMIT = 2'b01,
		SFM_MODE_POLICY = 2'b10,
		SFM_MODE_REDIRECT = 2'b11
	} sfm_mode_type;
	typedef struct packed {
		logic valid;
		logic [3:0] physical_ingress_port;
		logic [PORTS-1:0] forward_port_set;
		logic [QUEUES-1:0] host_queue_mask;
		logic learning_blocked_flag;
		logic forward_port_set_entry_hit;
		logic entry_skip_membership;
		logic [PORTS-1:0] vlan_member_mask;
		logic private_vlan_flag;
		logic vlan_source_check;
		logic vlan_no_learning;
		logic [3:0] aggregation_code;
		logic rule_host_copy_enable;
		logic [2:0] rule_host_queue_number;
		logic rule_learn_disable_sel;
		logic rule_first_hit_copy;
		logic [31:0] rule_match_counter;
		logic rule_first_lookup;
		logic rule_policer_enable;
		logic [POLICERS_W-1:0] rule_policer_index;
		logic rule_policer_exclusive;
		sfm_mode_type rule_mask_mode;
		logic [PORTS-1:0] rule_port_mask;
		logic rule_mirror_enable;
	} sfm_req_type;
	typedef struct packed {
		logic valid;
		logic [PORTS-1:0] forward_port_set;
		logic [QUEUES-1:0] host_queue_mask;
		logic learning_blocked_flag;
		logic policer_select;
		logic [POLICERS_W-1:0] policer_index;
		logic policer_exclusive;
		logic mirror_request;
	} sfm_res_type;
endpackage
`default_nettype wire

// [hw/sfm_stages.sv]
// VLAN, aggregation and rule action stages with AHB-Lite configuration
`default_nettype none
module sfm_stages (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Frame request from the earlier stages
	input wire sfm_pkg::sfm_req_type req,
	// Result for the later stages
	output sfm_pkg::sfm_res_type res
);
	function automatic logic port_bit(input logic [sfm_pkg::PORTS-1:0] m,
		input logic [3:0] p);
		port_bit = (p < 4'(sfm_pkg::PORTS)) ? m[p] : 1'b0;
	endfunction

	function automatic logic [sfm_pkg::QUEUES-1:0] queue_bit(
		input logic [2:0] q);
		queue_bit = sfm_pkg::QUEUES'(1) << q;
	endfunction

	logic [sfm_pkg::CTRL_W-1:0] ctrl;
	logic [sfm_pkg::PORTS-1:0] filter_mask;
	logic [sfm_pkg::PORTS-1:0] isolated_mask;
	logic [sfm_pkg::PORTS-1:0] community_mask;
	logic [sfm_pkg::PORTS-1:0] rx_forward_enable;
	logic [sfm_pkg::PORTS-1:0] port_group_mask_table [sfm_pkg::TABLE_ENTRIES];
	logic [sfm_pkg::COUNT_W-1:0] frame_count;
	logic [sfm_pkg::COUNT_W-1:0] blocked_count;

	// Bus address phase capture
	logic wr_pend;
	logic [11:0] wr_addr;
	wire logic take = hsel && hready && htrans[1];
	wire logic [11:0] a = haddr[11:0];
	wire logic in_table = a >= sfm_pkg::TABLE_ADDR &&
		a <= sfm_pkg::TABLE_END && a[1:0] == 2'b00;
	wire logic [5:0] rd_slot = 6'((a - sfm_pkg::TABLE_ADDR) >> 2);
	wire logic [5:0] wr_slot = 6'((wr_addr - sfm_pkg::TABLE_ADDR) >> 2);
	wire logic wr_table = wr_addr >= sfm_pkg::TABLE_ADDR &&
		wr_addr <= sfm_pkg::TABLE_END && wr_addr[1:0] == 2'b00;
	logic [31:0] next_rdata;

	always_comb begin
		if (a == sfm_pkg::CTRL_ADDR) begin
			next_rdata = 32'(ctrl);
		end else if (a == sfm_pkg::FILTER_ADDR) begin
			next_rdata = 32'(filter_mask);
		end else if (a == sfm_pkg::ISOLATED_ADDR) begin
			next_rdata = 32'(isolated_mask);
		end else if (a == sfm_pkg::COMMUNITY_ADDR) begin
			next_rdata = 32'(community_mask);
		end else if (a == sfm_pkg::RXEN_ADDR) begin
			next_rdata = 32'(rx_forward_enable);
		end else if (a == sfm_pkg::STATUS_ADDR) begin
			next_rdata = {blocked_count, frame_count};
		end else if (in_table) begin
			next_rdata = 32'(port_group_mask_table[rd_slot]);
		end else begin
			next_rdata = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= take && hwrite;
			if (take) begin
				wr_addr <= a;
			end
			if (take && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	// Unmapped writes are dropped; status and counters are read only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= sfm_pkg::CTRL_RESET;
			filter_mask <= sfm_pkg::NO_PORTS;
			isolated_mask <= sfm_pkg::ALL_PORTS;
			community_mask <= sfm_pkg::ALL_PORTS;
			rx_forward_enable <= sfm_pkg::ALL_PORTS;
			for (int i = 0; i < sfm_pkg::TABLE_ENTRIES; i++) begin
				// Source masks default to every port but the ingress one
				port_group_mask_table[i] <= (i >= sfm_pkg::SRC_SLOT &&
					i < sfm_pkg::SRC_SLOT + sfm_pkg::PORTS) ?
					sfm_pkg::ALL_PORTS & ~(sfm_pkg::PORTS'(1) <<
					(i - sfm_pkg::SRC_SLOT)) : sfm_pkg::ALL_PORTS;
			end
		end else if (wr_pend) begin
			if (wr_addr == sfm_pkg::CTRL_ADDR) begin
				ctrl <= hwdata[sfm_pkg::CTRL_W-1:0];
			end else if (wr_addr == sfm_pkg::FILTER_ADDR) begin
				filter_mask <= hwdata[sfm_pkg::PORTS-1:0];
			end else if (wr_addr == sfm_pkg::ISOLATED_ADDR) begin
				isolated_mask <= hwdata[sfm_pkg::PORTS-1:0];
			end else if (wr_addr == sfm_pkg::COMMUNITY_ADDR) begin
				community_mask <= hwdata[sfm_pkg::PORTS-1:0];
			end else if (wr_addr == sfm_pkg::RXEN_ADDR) begin
				rx_forward_enable <= hwdata[sfm_pkg::PORTS-1:0];
			end else if (wr_table) begin
				port_group_mask_table[wr_slot] <= hwdata[sfm_pkg::PORTS-1:0];
			end
		end
	end

	// VLAN analysis
	wire logic [3:0] pp = req.physical_ingress_port;
	wire logic skip_flags = ctrl[sfm_pkg::CTRL_SKIP_FORWARD_PORT_SET];
	wire logic skip_member = !skip_flags && ((req.forward_port_set_entry_hit &&
		req.entry_skip_membership) || (!req.forward_port_set_entry_hit &&
		ctrl[sfm_pkg::CTRL_FLOOD_SKIP]));
	wire logic [sfm_pkg::PORTS-1:0] member_keep = skip_member ?
		sfm_pkg::ALL_PORTS : req.vlan_member_mask;
	wire logic is_isolated = req.private_vlan_flag &&
		!port_bit(isolated_mask, pp);
	wire logic is_community = req.private_vlan_flag &&
		!port_bit(community_mask, pp);
	wire logic [sfm_pkg::PORTS-1:0] private_keep = is_isolated ?
		(isolated_mask & community_mask) : is_community ? isolated_mask :
		sfm_pkg::ALL_PORTS;
	wire logic filtering = port_bit(filter_mask, pp) ||
		req.vlan_source_check;
	wire logic filter_drop = filtering &&
		!port_bit(req.vlan_member_mask, pp);
	wire logic rx_drop = !port_bit(rx_forward_enable, pp);
	wire logic [5:0] src_slot = 6'(sfm_pkg::SRC_SLOT) + 6'(pp);
	wire logic [sfm_pkg::PORTS-1:0] src_keep =
		port_group_mask_table[src_slot];
	wire logic [sfm_pkg::PORTS-1:0] clear_keep =
		(filter_drop || rx_drop) ? sfm_pkg::NO_PORTS : sfm_pkg::ALL_PORTS;
	wire logic [sfm_pkg::PORTS-1:0] vlan_keep =
		member_keep & private_keep & src_keep & clear_keep;
	wire logic [sfm_pkg::PORTS-1:0] after_vlan =
		req.forward_port_set & vlan_keep;
	wire logic vlan_block = req.vlan_no_learning || (filter_drop &&
		ctrl[sfm_pkg::CTRL_LEARN_CHECK]);

	// Aggregation masking
	wire logic [sfm_pkg::PORTS-1:0] agg_keep =
		port_group_mask_table[6'(req.aggregation_code)];
	wire logic [sfm_pkg::PORTS-1:0] after_agg =
		after_vlan & agg_keep;

	// Rule action handling, applied in table order
	wire logic [sfm_pkg::QUEUES-1:0] qbit =
		queue_bit(req.rule_host_queue_number);
	wire logic [sfm_pkg::QUEUES-1:0] q_copy = req.rule_host_copy_enable ?
		qbit : sfm_pkg::NO_QUEUES;
	wire logic [sfm_pkg::QUEUES-1:0] q_once = (req.rule_first_hit_copy &&
		req.rule_match_counter == 32'h00000000) ?
		qbit : sfm_pkg::NO_QUEUES;
	wire logic [sfm_pkg::QUEUES-1:0] next_queue =
		req.host_queue_mask | q_copy | q_once;
	wire logic next_block = req.learning_blocked_flag || vlan_block ||
		req.rule_learn_disable_sel;
	wire logic next_police = req.rule_first_lookup &&
		req.rule_policer_enable;
	wire logic next_exclusive = req.rule_first_lookup &&
		req.rule_policer_exclusive;
	// Policy replaces the lookup result, the VLAN and aggregation masks still prune it
	wire logic [sfm_pkg::PORTS-1:0] policy_set =
		req.rule_port_mask & vlan_keep & agg_keep;
	logic [sfm_pkg::PORTS-1:0] next_forward_port_set;

	always_comb begin
		case (req.rule_mask_mode)
			sfm_pkg::SFM_MODE_PERMIT: begin
				next_forward_port_set = after_agg & req.rule_port_mask;
			end
			sfm_pkg::SFM_MODE_POLICY: begin
				next_forward_port_set = policy_set;
			end
			sfm_pkg::SFM_MODE_REDIRECT: begin
				next_forward_port_set = req.rule_port_mask;
			end
			default: begin
				next_forward_port_set = after_agg;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res <= '0;
			frame_count <= '0;
			blocked_count <= '0;
		end else begin
			res.valid <= req.valid;
			res.forward_port_set <= req.valid ? next_forward_port_set : sfm_pkg::NO_PORTS;
			res.host_queue_mask <= req.valid ? next_queue :
				sfm_pkg::NO_QUEUES;
			res.learning_blocked_flag <= req.valid && next_block;
			res.policer_select <= req.valid && next_police;
			res.policer_index <= req.rule_policer_index;
			res.policer_exclusive <= req.valid && next_exclusive;
			res.mirror_request <= req.valid &&
				req.rule_mirror_enable;
			frame_count <= frame_count + COUNT_ONE(req.valid);
			blocked_count <= blocked_count +
				COUNT_ONE(req.valid && next_block);
		end
	end

	function automatic logic [sfm_pkg::COUNT_W-1:0] COUNT_ONE(input logic b);
		COUNT_ONE = {{(sfm_pkg::COUNT_W-1){1'b0}}, b};
	endfunction

	a_member_prune: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && req.rule_mask_mode != sfm_pkg::SFM_MODE_REDIRECT &&
		!skip_member |=> (res.forward_port_set &
		~$past(req.vlan_member_mask)) == sfm_pkg::NO_PORTS)
		else $error("non-member port forwarded");
	a_skip_forced: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && skip_flags &&
		req.rule_mask_mode != sfm_pkg::SFM_MODE_REDIRECT
		|=> (res.forward_port_set & ~$past(req.vlan_member_mask))
		== sfm_pkg::NO_PORTS)
		else $error("membership skip with forward_port_set flags ignored");
	a_filter_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && filter_drop &&
		req.rule_mask_mode != sfm_pkg::SFM_MODE_REDIRECT
		|=> res.forward_port_set == sfm_pkg::NO_PORTS)
		else $error("ingress filter did not clear set");
	a_rx_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && !port_bit(rx_forward_enable, pp) &&
		req.rule_mask_mode != sfm_pkg::SFM_MODE_REDIRECT
		|=> res.forward_port_set == sfm_pkg::NO_PORTS)
		else $error("receive disable did not clear set");
	a_isolated_prune: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && is_isolated &&
		req.rule_mask_mode != sfm_pkg::SFM_MODE_REDIRECT
		|=> (res.forward_port_set & ~$past(isolated_mask & community_mask))
		== sfm_pkg::NO_PORTS)
		else $error("isolated frame reached private port");
	a_learn_check: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && filter_drop && ctrl[sfm_pkg::CTRL_LEARN_CHECK]
		|=> res.learning_blocked_flag)
		else $error("filter drop left learning on");
	a_host_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && req.rule_host_copy_enable
		|=> res.host_queue_mask[$past(req.rule_host_queue_number)])
		else $error("host copy queue bit missing");
	a_redirect_mask: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && req.rule_mask_mode == sfm_pkg::SFM_MODE_REDIRECT
		|=> res.forward_port_set == $past(req.rule_port_mask))
		else $error("redirect did not replace set");
	a_police_first: assert property (@(posedge hclk) disable iff (!hresetn)
		res.policer_select |-> $past(req.rule_first_lookup))
		else $error("policer chosen outside first lookup");
	a_agg_prune: assert property (@(posedge hclk) disable iff (!hresetn)
		req.valid && req.rule_mask_mode == sfm_pkg::SFM_MODE_NONE
		|=> (res.forward_port_set & ~$past(agg_keep))
		== sfm_pkg::NO_PORTS)
		else $error("port outside aggregation mask kept");
	c_filter_drop: cover property (@(posedge hclk) req.valid && filter_drop);
	c_private_comm: cover property (@(posedge hclk)
		req.valid && is_community && !is_isolated);
	c_policy: cover property (@(posedge hclk)
		req.valid && req.rule_mask_mode == sfm_pkg::SFM_MODE_POLICY);
	c_bus_write: cover property (@(posedge hclk) wr_pend && wr_table);
endmodule
`default_nettype wire

// [tb/sfm_feeder.sv]
// Upstream model: classifier and table lookups presenting one request
`default_nettype none
module sfm_feeder (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request from the bench
	input wire logic go,
	input wire sfm_pkg::sfm_req_type nxt,
	// Request into the stages
	output sfm_pkg::sfm_req_type req
);
	timeunit 1ns;
	timeprecision 1ns;
	sfm_pkg::sfm_req_type idle;
	// Stale fields toggle so a missed valid check cannot pass by luck
	assign idle = {1'b0, ~req[$bits(req)-2:0]};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
		end else begin
			req <= go ? nxt : idle;
		end
	end
endmodule
`default_nettype wire

// [tb/sfm_stages_bench.sv]
// Self-checking bench for the forward mask stages
`default_nettype none
module sfm_stages_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk;
	logic hresetn;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	wire logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic go;
	sfm_pkg::sfm_req_type nxt;
	sfm_pkg::sfm_req_type req;
	sfm_pkg::sfm_res_type res;
	sfm_pkg::sfm_req_type b;
	sfm_pkg::sfm_req_type r;
	int failures;
	int checked;
	int frames;
	int blocked;
	logic [2:0] ctrl;
	logic [10:0] filt;
	logic [10:0] iso;
	logic [10:0] com;
	logic [10:0] rxen;
	logic [10:0] agg [16];
	logic [10:0] src [11];
	assign hready = hreadyout;
	sfm_feeder u_feed (.hclk(hclk), .hresetn(hresetn), .go(go),
		.nxt(nxt), .req(req));
	sfm_stages u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.req(req), .res(res));
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic final_report;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			failures++;
			final_report();
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		haddr <= {20'h00000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		check({31'h00000000, hresp}, 32'h00000000);
	endtask
	task automatic expect_rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(q, e);
	endtask
	task automatic set(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		int i;
		bus(1'b1, a, d, q);
		i = int'((a - sfm_pkg::TABLE_ADDR) >> 2);
		if (a >= sfm_pkg::TABLE_ADDR && i < 16) agg[i] = d[10:0];
		else if (a >= sfm_pkg::TABLE_ADDR) src[i - 16] = d[10:0];
		case (a)
			sfm_pkg::CTRL_ADDR: ctrl = d[2:0];
			sfm_pkg::FILTER_ADDR: filt = d[10:0];
			sfm_pkg::ISOLATED_ADDR: iso = d[10:0];
			sfm_pkg::COMMUNITY_ADDR: com = d[10:0];
			sfm_pkg::RXEN_ADDR: rxen = d[10:0];
			default: ;
		endcase
	endtask
	function automatic logic drop(input sfm_pkg::sfm_req_type x);
		logic [3:0] p;
		p = x.physical_ingress_port;
		return (filt[p] | x.vlan_source_check) & ~x.vlan_member_mask[p];
	endfunction
	function automatic logic [10:0] keep(input logic [10:0] d,
		input sfm_pkg::sfm_req_type x);
		logic [3:0] p;
		logic skip;
		p = x.physical_ingress_port;
		skip = !ctrl[0] &&
			(x.forward_port_set_entry_hit ? x.entry_skip_membership : ctrl[1]);
		if (!skip) d &= x.vlan_member_mask;
		if (x.private_vlan_flag && !iso[p]) d &= iso & com;
		else if (x.private_vlan_flag && !com[p]) d &= iso;
		if (drop(x) || !rxen[p]) d = 11'h000;
		return d & src[p] & agg[x.aggregation_code];
	endfunction
	// Result worked out independently and compared two edges after the request reaches the stages
	task automatic frame(input sfm_pkg::sfm_req_type x);
		sfm_pkg::sfm_res_type e;
		logic [10:0] d;
		d = keep(x.forward_port_set, x);
		if (x.rule_mask_mode == sfm_pkg::SFM_MODE_PERMIT) d &= x.rule_port_mask;
		if (x.rule_mask_mode == sfm_pkg::SFM_MODE_POLICY)
			d = keep(x.rule_port_mask, x);
		if (x.rule_mask_mode == sfm_pkg::SFM_MODE_REDIRECT) d = x.rule_port_mask;
		e.valid = 1'b1;
		e.forward_port_set = d;
		e.host_queue_mask = x.host_queue_mask;
		if (x.rule_host_copy_enable || (x.rule_first_hit_copy &&
			x.rule_match_counter == 32'h00000000))
			e.host_queue_mask |= 8'h01 << x.rule_host_queue_number;
		e.learning_blocked_flag = x.learning_blocked_flag |
			x.vlan_no_learning | (drop(x) & ctrl[2]) |
			x.rule_learn_disable_sel;
		e.policer_select = x.rule_first_lookup & x.rule_policer_enable;
		e.policer_index = x.rule_policer_index;
		e.policer_exclusive = x.rule_first_lookup & x.rule_policer_exclusive;
		e.mirror_request = x.rule_mirror_enable;
		frames++;
		blocked += int'(e.learning_blocked_flag);
		@(posedge hclk);
		nxt <= x;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		@(posedge hclk);
		check({3'h0, res}, {3'h0, e});
	endtask
	initial begin
		hresetn = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		go = 1'b0;
		nxt = '0;
		failures = 0;
		checked = 0;
		frames = 0;
		blocked = 0;
		ctrl = 3'h0;
		filt = 11'h000;
		iso = 11'h7FF;
		com = 11'h7FF;
		rxen = 11'h7FF;
		for (int i = 0; i < 16; i++) agg[i] = 11'h7FF;
		for (int i = 0; i < 11; i++) src[i] = 11'h7FF & ~(11'h001 << i);
		b = '0;
		b.valid = 1'b1;
		b.physical_ingress_port = 4'h3;
		b.forward_port_set = 11'h7FF;
		b.vlan_member_mask = 11'h7FF;
		b.rule_match_counter = 32'h00000001;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		expect_rd(sfm_pkg::CTRL_ADDR, 32'h00000000);
		expect_rd(sfm_pkg::ISOLATED_ADDR, 32'h000007FF);
		expect_rd(sfm_pkg::TABLE_ADDR, 32'h000007FF);
		expect_rd(sfm_pkg::TABLE_END, 32'h000007FF);
		expect_rd(sfm_pkg::TABLE_ADDR + 12'((sfm_pkg::SRC_SLOT + 10) * 4),
			32'h000003FF);
		set(12'h018, 32'hFFFFFFFF);
		expect_rd(12'h018, 32'h00000000);
		$display("test registers done");
		r = b;
		r.vlan_member_mask = 11'h0F0;
		frame(r);
		r.forward_port_set_entry_hit = 1'b1;
		r.entry_skip_membership = 1'b1;
		frame(r);
		set(sfm_pkg::CTRL_ADDR, 32'h00000001);
		frame(r);
		set(sfm_pkg::CTRL_ADDR, 32'h00000002);
		r.forward_port_set_entry_hit = 1'b0;
		frame(r);
		set(sfm_pkg::CTRL_ADDR, 32'h00000007);
		frame(r);
		r = b;
		r.private_vlan_flag = 1'b1;
		set(sfm_pkg::ISOLATED_ADDR, 32'h000007F7);
		set(sfm_pkg::COMMUNITY_ADDR, 32'h000007CF);
		frame(r);
		set(sfm_pkg::ISOLATED_ADDR, 32'h000005FF);
		set(sfm_pkg::COMMUNITY_ADDR, 32'h000007F3);
		frame(r);
		r = b;
		r.vlan_member_mask = 11'h7F0;
		set(sfm_pkg::FILTER_ADDR, 32'h00000008);
		frame(r);
		set(sfm_pkg::FILTER_ADDR, 32'h00000000);
		frame(r);
		r.vlan_source_check = 1'b1;
		frame(r);
		r = b;
		r.vlan_no_learning = 1'b1;
		frame(r);
		set(sfm_pkg::RXEN_ADDR, 32'h000007F7);
		frame(b);
		set(sfm_pkg::RXEN_ADDR, 32'h000007FF);
		set(sfm_pkg::TABLE_ADDR + 12'((sfm_pkg::SRC_SLOT + 3) * 4), 32'h0000004F);
		frame(b);
		$display("test vlan done");
		set(sfm_pkg::TABLE_ADDR + 12'h03C, 32'h00000421);
		r = b;
		r.aggregation_code = 4'hF;
		frame(r);
		$display("test aggregation done");
		for (int m = 0; m < 4; m++) begin
			r = b;
			r.rule_mask_mode = sfm_pkg::sfm_mode_type'(m);
			r.rule_port_mask = 11'h0A5;
			r.vlan_member_mask = 11'h3F7;
			frame(r);
		end
		r = b;
		r.host_queue_mask = 8'h01;
		r.rule_host_copy_enable = 1'b1;
		r.rule_host_queue_number = 3'h7;
		frame(r);
		r = b;
		r.rule_first_hit_copy = 1'b1;
		r.rule_host_queue_number = 3'h2;
		frame(r);
		r.rule_match_counter = 32'h00000000;
		frame(r);
		r = b;
		r.rule_learn_disable_sel = 1'b1;
		frame(r);
		r = b;
		r.rule_policer_enable = 1'b1;
		r.rule_policer_exclusive = 1'b1;
		r.rule_policer_index = 5'h1F;
		r.rule_mirror_enable = 1'b1;
		frame(r);
		r.rule_first_lookup = 1'b1;
		frame(r);
		expect_rd(sfm_pkg::STATUS_ADDR, {16'(blocked), 16'(frames)});
		$display("test rule actions done");
		final_report();
	end
endmodule
`default_nettype wire
